// file: pkg/tcs_pkg.sv
// tcs_pkg: constants and types for the type-c status indication block
// assumes a single 250 MHz clock and an AHB-Lite register bus
package tcs_pkg;

    // state reported by the type-c state machine, same clock domain
    typedef enum logic [2:0] {
        tcs_st_unattached,
        tcs_st_attached_snk,
        tcs_st_attached_src,
        tcs_st_audio_acc,
        tcs_st_dbg_acc_snk,
        tcs_st_unor_dbg_src,
        tcs_st_or_dbg_src,
        tcs_st_other
    } tcs_tc_state_e;

    // register byte offsets
    localparam logic [7:0] TCS_OFS_STATUS   = 8'h00;
    localparam logic [7:0] TCS_OFS_INT_STAT = 8'h04;
    localparam logic [7:0] TCS_OFS_INT_MASK = 8'h08;
    localparam logic [7:0] TCS_OFS_CTRL     = 8'h0C;
    localparam logic [7:0] TCS_OFS_PINS     = 8'h10;
    localparam logic [7:0] TCS_OFS_NONE     = 8'hFC;

    // status and control field positions
    localparam int TCS_BIT_VALID   = 0;
    localparam int TCS_BIT_ATTACH  = 1;
    localparam int TCS_BIT_SNK_DBG = 2;
    localparam int TCS_BIT_SRC_DBG = 3;
    localparam int TCS_BIT_ORIENT  = 4;
    localparam int TCS_BIT_VC_CC1  = 5;
    localparam int TCS_BIT_VC_CC2  = 6;
    localparam int TCS_BIT_VC_EN   = 0;

    // field widths
    localparam int TCS_LIVE_W = 7;
    localparam int TCS_EVT_W  = 5;
    localparam int TCS_SYNC_W = 7;

    // values after reset
    localparam logic [TCS_LIVE_W-1:0] TCS_LIVE_RST = 7'h00;
    localparam logic [TCS_EVT_W-1:0]  TCS_FLAG_RST = 5'h00;
    localparam logic [TCS_EVT_W-1:0]  TCS_MASK_RST = 5'h00;
    localparam logic                  TCS_VCEN_RST = 1'b0;
    localparam logic [TCS_SYNC_W-1:0] TCS_SYNC_RST = 7'h7C;

    // ahb encodings
    localparam logic [2:0] TCS_HSIZE_WORD = 3'h2;
    localparam logic       TCS_HRESP_OKAY = 1'b0;

endpackage : tcs_pkg

// file: pkg/tcs_reg_if.sv
// tcs_reg_if: register access strobes between bus slave and status core
// assumes both ends on clock_i; strobes are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface tcs_reg_if;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport bus_side (output wr, output rd, output addr, output wdata, input rdata);
    modport reg_side (input wr, input rd, input addr, input wdata, output rdata);
endinterface : tcs_reg_if
`default_nettype wire

// file: rtl/tcs_sync.sv
// tcs_sync: three-stage synchroniser with agreement filter
// assumes inputs are asynchronous levels; output moves when stages 2 and 3 agree
`timescale 1ns/1ns
`default_nettype none
module tcs_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } tcs_sync_s;

    tcs_sync_s sync_reg;
    tcs_sync_s sync_next;
    logic [W-1:0] agree;

    // stage 1 feeds only stage 2, so no gate sees a metastable value
    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = d_i;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        agree        = ~(sync_reg.s2 ^ sync_reg.s3);
        sync_next.q  = (sync_reg.s2 & agree) | (sync_reg.q & ~agree);
    end

    // state register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_reg <= {4{RST_VAL}};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q_o = sync_reg.q;
endmodule : tcs_sync
`default_nettype wire

// file: rtl/tcs_ahb_slave.sv
// tcs_ahb_slave: AHB-Lite slave turning bus transfers into register strobes
// assumes a single master and that hready_i is this slave's own hreadyout_o
`timescale 1ns/1ns
`default_nettype none
module tcs_ahb_slave (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    tcs_reg_if.bus_side      regs
);
    import tcs_pkg::*;

    typedef enum logic [1:0] {tcs_bs_idle, tcs_bs_write, tcs_bs_read1, tcs_bs_read2} tcs_bs_e;
    typedef struct packed {
        tcs_bs_e     state;
        logic [7:0]  addr;
        logic        word_ok;
        logic [31:0] rdata;
    } tcs_bs_s;

    tcs_bs_s bs_reg;
    tcs_bs_s bs_next;
    logic    accept;

    // reads take one wait state so hrdata comes from a flop
    always_comb begin
        bs_next = bs_reg;
        accept  = hsel_i & htrans_i[1] & hready_i;
        if (bs_reg.state == tcs_bs_read1) begin
            bs_next.rdata = regs.rdata;
            bs_next.state = tcs_bs_read2;
        end else if (accept) begin
            bs_next.addr    = (haddr_i[31:8] == 24'h000000) ? haddr_i[7:0] : TCS_OFS_NONE;
            bs_next.word_ok = (hsize_i == TCS_HSIZE_WORD);
            bs_next.state   = hwrite_i ? tcs_bs_write : tcs_bs_read1;
        end else begin
            bs_next.state = tcs_bs_idle;
        end
    end

    // state register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bs_reg <= '{state: tcs_bs_idle, addr: 8'h00, word_ok: 1'b0, rdata: 32'h00000000};
        end else begin
            bs_reg <= bs_next;
        end
    end

    // strobes; sub-word writes are dropped, answer stays okay
    assign regs.wr     = (bs_reg.state == tcs_bs_write) & bs_reg.word_ok;
    assign regs.rd     = (bs_reg.state == tcs_bs_read1);
    assign regs.addr   = bs_reg.addr;
    assign regs.wdata  = hwdata_i;
    assign hreadyout_o = (bs_reg.state != tcs_bs_read1);
    assign hresp_o     = TCS_HRESP_OKAY;
    assign hrdata_o    = bs_reg.rdata;
endmodule : tcs_ahb_slave
`default_nettype wire

// file: rtl/tcs_status_top.sv
// tcs_status_top: type-c status indicator pins, vconn routing and mirror registers
// assumes type-c state machine inputs on clock_i; sense inputs are asynchronous
// Behaviour
// (R1) bus-valid pin asserts only when attached, power sensed and within range
// (R2) attach pin asserts when a source-to-sink connection is established
// (R3) attach pin also asserts when an accessory is connected
// (R4) sink debug pin asserts only in sink role debug-accessory state
// (R5) source debug pin asserts only in source role debug-accessory states
// (R6) orientation pin released when channel one carries the cc line
// (R7) orientation pin driven low when channel two carries the cc line
// (R8) every indicator is active-low open drain: pull low or release
// (R9) reset input is active high and holds the logic in reset
// (R10) source with connection and switch enabled powers the unused channel
// (R11) attach state readable in a status register bit
// (R12) orientation readable in a status register bit
// (R13) during reset all indicators released and mirror bits cleared
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tcs_status_top (
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire tcs_pkg::tcs_tc_state_e tc_state_i,
    input  wire logic                   src_role_i,
    input  wire logic                   cc2_active_i,
    input  wire logic                   bus_power_sense_i,
    input  wire logic                   bus_power_in_range_i,
    input  wire logic                   bus_power_valid_n_in_i,
    output logic                        bus_power_valid_n_o,
    output logic                        bus_power_valid_n_oe_n_o,
    input  wire logic                   attach_n_in_i,
    output logic                        attach_n_o,
    output logic                        attach_n_oe_n_o,
    input  wire logic                   sink_dbg_acc_n_in_i,
    output logic                        sink_dbg_acc_n_o,
    output logic                        sink_dbg_acc_n_oe_n_o,
    input  wire logic                   source_dbg_acc_n_in_i,
    output logic                        source_dbg_acc_n_o,
    output logic                        source_dbg_acc_n_oe_n_o,
    input  wire logic                   orient_n_in_i,
    output logic                        orient_n_o,
    output logic                        orient_n_oe_n_o,
    output logic                        vconn_cc1_en_o,
    output logic                        vconn_cc2_en_o,
    output logic                        irq_o,
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    output logic      [31:0]            hrdata_o
);
    import tcs_pkg::*;

    typedef struct packed {
        logic [TCS_LIVE_W-1:0] live;
        logic [TCS_EVT_W-1:0]  flags;
        logic [TCS_EVT_W-1:0]  mask;
        logic                  vconn_sw_en;
        logic                  irq;
    } tcs_core_s;

    tcs_core_s               core_reg;
    tcs_core_s               core_next;
    logic [TCS_SYNC_W-1:0]   sync_d;
    logic [TCS_SYNC_W-1:0]   sync_q;
    logic                    sense_q;
    logic                    range_q;
    logic                    attached;
    logic                    src_conn;
    logic [TCS_EVT_W-1:0]    events;
    logic [TCS_EVT_W-1:0]    clear;
    logic [31:0]             rd_mux;

    tcs_reg_if regs ();

    // any state in which a partner of some kind is attached
    function automatic logic is_attached(input tcs_tc_state_e st);
        is_attached = (st == tcs_st_attached_snk) || (st == tcs_st_attached_src) ||
                      (st == tcs_st_audio_acc) || (st == tcs_st_dbg_acc_snk) ||
                      (st == tcs_st_unor_dbg_src) || (st == tcs_st_or_dbg_src);
    endfunction : is_attached

    // both source-side debug accessory states
    function automatic logic is_src_dbg(input tcs_tc_state_e st);
        is_src_dbg = (st == tcs_st_unor_dbg_src) || (st == tcs_st_or_dbg_src);
    endfunction : is_src_dbg

    // analog comparator results and pin readback cross into clock_i
    assign sync_d = {orient_n_in_i, source_dbg_acc_n_in_i, sink_dbg_acc_n_in_i,
                     attach_n_in_i, bus_power_valid_n_in_i,
                     bus_power_in_range_i, bus_power_sense_i};

    tcs_sync #(
        .W       (TCS_SYNC_W),
        .RST_VAL (TCS_SYNC_RST)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (sync_d),
        .q_o     (sync_q)
    );

    assign sense_q = sync_q[0];
    assign range_q = sync_q[1];

    tcs_ahb_slave u_bus (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (hsize_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hready_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .regs        (regs.bus_side)
    );

    // indicator decode, interrupt flags and register writes
    always_comb begin
        core_next = core_reg;
        attached  = is_attached(tc_state_i);
        // (R1) valid needs attach and power in range
        core_next.live[TCS_BIT_VALID] = attached & sense_q & range_q;
        // (R2) (R3) connection or accessory
        core_next.live[TCS_BIT_ATTACH] = attached;
        // (R4) sink role debug
        core_next.live[TCS_BIT_SNK_DBG] = ~src_role_i & (tc_state_i == tcs_st_dbg_acc_snk);
        // (R5) source role debug
        core_next.live[TCS_BIT_SRC_DBG] = src_role_i & is_src_dbg(tc_state_i);
        // (R6) (R7) orientation only while attached
        core_next.live[TCS_BIT_ORIENT] = attached & cc2_active_i;
        // (R10) vconn onto the unused channel
        src_conn = src_role_i & (tc_state_i == tcs_st_attached_src) & core_reg.vconn_sw_en;
        core_next.live[TCS_BIT_VC_CC1] = src_conn & cc2_active_i;
        core_next.live[TCS_BIT_VC_CC2] = src_conn & ~cc2_active_i;
        // any change of an indicator is an event; set beats read-clear
        events = core_next.live[TCS_EVT_W-1:0] ^ core_reg.live[TCS_EVT_W-1:0];
        clear  = (regs.rd && regs.addr == TCS_OFS_INT_STAT) ? 5'h1F : 5'h00;
        core_next.flags = (core_reg.flags & ~clear) | events;
        if (regs.wr && regs.addr == TCS_OFS_INT_MASK) begin
            core_next.mask = regs.wdata[TCS_EVT_W-1:0];
        end
        if (regs.wr && regs.addr == TCS_OFS_CTRL) begin
            core_next.vconn_sw_en = regs.wdata[TCS_BIT_VC_EN];
        end
        core_next.irq = |(core_next.flags & core_next.mask);
    end

    // (R11) (R12) readback mux, unmapped reads as zero
    always_comb begin
        case (regs.addr)
            TCS_OFS_STATUS:   rd_mux = {25'h0000000, core_reg.live};
            TCS_OFS_INT_STAT: rd_mux = {27'h0000000, core_reg.flags};
            TCS_OFS_INT_MASK: rd_mux = {27'h0000000, core_reg.mask};
            TCS_OFS_CTRL:     rd_mux = {31'h00000000, core_reg.vconn_sw_en};
            TCS_OFS_PINS:     rd_mux = {27'h0000000, sync_q[6:2]};
            default:          rd_mux = 32'h00000000;
        endcase
    end
    assign regs.rdata = rd_mux;

    // (R9) (R13) active-high async reset clears mirrors, pins released
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            core_reg <= '{live: TCS_LIVE_RST, flags: TCS_FLAG_RST, mask: TCS_MASK_RST,
                          vconn_sw_en: TCS_VCEN_RST, irq: 1'b0};
        end else begin
            core_reg <= core_next;
        end
    end

    // (R8) open drain: data always low, enable low only when asserted
    assign bus_power_valid_n_o      = 1'b0;
    assign attach_n_o               = 1'b0;
    assign sink_dbg_acc_n_o         = 1'b0;
    assign source_dbg_acc_n_o       = 1'b0;
    assign orient_n_o               = 1'b0;
    assign bus_power_valid_n_oe_n_o = ~core_reg.live[TCS_BIT_VALID];
    assign attach_n_oe_n_o          = ~core_reg.live[TCS_BIT_ATTACH];
    assign sink_dbg_acc_n_oe_n_o    = ~core_reg.live[TCS_BIT_SNK_DBG];
    assign source_dbg_acc_n_oe_n_o  = ~core_reg.live[TCS_BIT_SRC_DBG];
    assign orient_n_oe_n_o          = ~core_reg.live[TCS_BIT_ORIENT];
    assign vconn_cc1_en_o           = core_reg.live[TCS_BIT_VC_CC1];
    assign vconn_cc2_en_o           = core_reg.live[TCS_BIT_VC_CC2];
    assign irq_o                    = core_reg.irq;

    // checks on the driven indicators
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_valid_needs_attach: assert property (!bus_power_valid_n_oe_n_o |-> !attach_n_oe_n_o) // (R1)
        else $error("bus valid asserted without attach");
    a_valid_needs_range: assert property ( // (R1)
        !bus_power_valid_n_oe_n_o |-> $past(sense_q && range_q))
        else $error("bus valid asserted without power in range");
    // the first edge after a release still shows released pins, so causes seen in reset are skipped
    a_attach_on_conn: assert property ( // (R2)
        !$past(rst_i) && $past(tc_state_i == tcs_st_attached_snk ||
        tc_state_i == tcs_st_attached_src) |-> !attach_n_oe_n_o)
        else $error("attach not asserted on connection");
    a_attach_on_acc: assert property ( // (R3)
        !$past(rst_i) && $past(tc_state_i == tcs_st_audio_acc) |-> !attach_n_oe_n_o)
        else $error("attach not asserted on accessory");
    a_sink_dbg_cause: assert property ( // (R4)
        !$past(rst_i) |-> (!sink_dbg_acc_n_oe_n_o <->
        $past(!src_role_i && tc_state_i == tcs_st_dbg_acc_snk)))
        else $error("sink debug pin wrong");
    a_src_dbg_cause: assert property ( // (R5)
        !$past(rst_i) |-> (!source_dbg_acc_n_oe_n_o <->
        $past(src_role_i && is_src_dbg(tc_state_i))))
        else $error("source debug pin wrong");
    a_orient_cc1_hiz: assert property ($past(!cc2_active_i) |-> orient_n_oe_n_o) // (R6)
        else $error("orientation driven for channel one");
    a_orient_cc2_low: assert property ( // (R7)
        !$past(rst_i) && $past(cc2_active_i && is_attached(tc_state_i)) |-> !orient_n_oe_n_o)
        else $error("orientation not driven for channel two");
    a_open_drain_low: assert property ( // (R8)
        (!attach_n_oe_n_o |-> !attach_n_o) and (!orient_n_oe_n_o |-> !orient_n_o))
        else $error("open drain pin driven high");
    a_vconn_unused_cc: assert property ( // (R10)
        vconn_cc1_en_o |->
        (!vconn_cc2_en_o && $past(cc2_active_i && core_reg.vconn_sw_en && src_role_i)))
        else $error("vconn on wrong channel");
    a_attach_mirror: assert property ( // (R11)
        regs.rd && regs.addr == TCS_OFS_STATUS |-> regs.rdata[TCS_BIT_ATTACH] == !attach_n_oe_n_o)
        else $error("attach mirror differs from pin");
    a_orient_mirror: assert property ( // (R12)
        regs.rd && regs.addr == TCS_OFS_STATUS |-> regs.rdata[TCS_BIT_ORIENT] == !orient_n_oe_n_o)
        else $error("orientation mirror differs from pin");
    a_flag_set_wins: assert property ( // interrupt flags: a new event beats the read-clear
        (events != 5'h00) |=> ((core_reg.flags & $past(events)) == $past(events)))
        else $error("event lost on clear");
    a_reset_released: assert property (@(posedge clock_i) disable iff (1'b0) // (R13)
        rst_i |-> (attach_n_oe_n_o && orient_n_oe_n_o && bus_power_valid_n_oe_n_o &&
        sink_dbg_acc_n_oe_n_o && source_dbg_acc_n_oe_n_o &&
        core_reg.live == TCS_LIVE_RST))
        else $error("indicator active during reset");

    c_attach_seen: cover property (!attach_n_oe_n_o ##1 attach_n_oe_n_o);
    c_src_dbg_seen: cover property (!source_dbg_acc_n_oe_n_o);
    c_vconn_cc1: cover property (vconn_cc1_en_o);
    c_irq_cleared: cover property (irq_o ##[1:20] !irq_o);
endmodule : tcs_status_top
`default_nettype wire

// file: verif/tcs_host_model.sv
// tcs_host_model: pull-up network of the host controller and the data mux inputs
// assumes the five indicator pins are open drain, each with an external pull-up
`timescale 1ns/1ns
`default_nettype none
module tcs_host_model (
    input  wire logic [4:0] pin_n_o_i,
    input  wire logic [4:0] pin_oe_n_i,
    output logic      [4:0] pin_lvl_o
);
    // wired pin level
    // a released pin floats up to the pull-up and never keeps the last driven value
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            pin_lvl_o[k] = pin_oe_n_i[k] ? 1'b1 : pin_n_o_i[k];
        end
    end
endmodule : tcs_host_model
`default_nettype wire

// file: verif/tcs_status_top_tb_top.sv
// tcs_status_top_tb_top: self-checking bench for the type-c status indicator block
// assumes hready_i fed back from hreadyout_o and the host model supplying pin levels
`timescale 1ns/1ns
`default_nettype none
module tcs_status_top_tb_top;
    import tcs_pkg::*;
    logic           clock_i    = 1'b0;
    logic           rst_i      = 1'b0;
    tcs_tc_state_e  tc_state_i = tcs_st_unattached;
    logic           src_role_i = 1'b0;
    logic           cc2_i      = 1'b0;
    logic           sense_i    = 1'b0;
    logic           range_i    = 1'b0;
    logic           hsel_i     = 1'b0;
    logic    [31:0] haddr_i    = 32'h0;
    logic     [1:0] htrans_i   = 2'h0;
    logic           hwrite_i   = 1'b0;
    logic     [2:0] hsize_i    = 3'h2;
    logic    [31:0] hwdata_i   = 32'h0;
    wire logic [4:0] oe_n, n_o, lvl;
    wire logic      vc1, vc2, irq, hready, hresp;
    wire logic [31:0] hrdata;
    logic [31:0]    rd_q[$];
    logic [31:0]    exp_w;
    bit             rd_phase   = 1'b0;
    int             failures   = 0;
    int             n_checks   = 0;

    always #2 clock_i = ~clock_i;

    tcs_status_top tcs_status_top_i (.clock_i(clock_i), .rst_i(rst_i),
        .tc_state_i(tc_state_i), .src_role_i(src_role_i), .cc2_active_i(cc2_i),
        .bus_power_sense_i(sense_i), .bus_power_in_range_i(range_i),
        .bus_power_valid_n_in_i(lvl[0]), .bus_power_valid_n_o(n_o[0]),
        .bus_power_valid_n_oe_n_o(oe_n[0]), .attach_n_in_i(lvl[1]), .attach_n_o(n_o[1]),
        .attach_n_oe_n_o(oe_n[1]), .sink_dbg_acc_n_in_i(lvl[2]), .sink_dbg_acc_n_o(n_o[2]),
        .sink_dbg_acc_n_oe_n_o(oe_n[2]), .source_dbg_acc_n_in_i(lvl[3]),
        .source_dbg_acc_n_o(n_o[3]), .source_dbg_acc_n_oe_n_o(oe_n[3]),
        .orient_n_in_i(lvl[4]), .orient_n_o(n_o[4]), .orient_n_oe_n_o(oe_n[4]),
        .vconn_cc1_en_o(vc1), .vconn_cc2_en_o(vc2), .irq_o(irq), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata));

    tcs_host_model tcs_host_model_i (.pin_n_o_i(n_o), .pin_oe_n_i(oe_n), .pin_lvl_o(lvl));

    // single compare point, counts every comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // hready is looked at mid-cycle, where it already holds its value for the next edge
    task automatic wait_rdy();
        logic r;
        do begin
            @(negedge clock_i);
            r = hready;
            @(posedge clock_i);
        end while (r !== 1'b1);
    endtask : wait_rdy

    // one single-word transfer: address phase held until ready, then the data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i  <= {24'h0, a};
        hsize_i  <= TCS_HSIZE_WORD;
        wait_rdy();
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        rd_phase = !w;
        wait_rdy();
        rd_phase = 1'b0;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    // the expected read value is noted before the transfer starts
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask : rd

    // pin enables, open-drain data, vconn routing and interrupt, sampled mid-cycle
    task automatic pins_chk(input logic [4:0] e_oe, input logic [1:0] e_vc, input logic e_irq);
        @(negedge clock_i);
        chk({27'h0, oe_n}, {27'h0, e_oe});
        chk({27'h0, n_o}, 32'h0);
        chk({30'h0, vc2, vc1}, {30'h0, e_vc});
        chk({31'h0, irq}, {31'h0, e_irq});
        @(posedge clock_i);
    endtask : pins_chk

    // read monitor: oldest note against the data of the completing read
    always @(negedge clock_i) begin
        if (rd_phase && hready === 1'b1) begin
            exp_w = rd_q.pop_front();
            chk(hrdata, exp_w);
            chk({31'h0, hresp}, 32'h0);
        end
    end

    // watchdog sized at many times the expected run length
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        tally_and_finish();
    end

    // main sequence: reset, every state by role and orientation, then a mid-run reset
    initial begin
        logic [4:0] st, prev, msk, flg, mid;
        logic       ctl, sn, rg, att, vc, c2;
        tcs_tc_state_e s;
        // a real rising edge at time zero, so the asynchronous reset acts before the first clock
        rst_i <= 1'b1;
        prev = 5'h00;
        void'($urandom(32'h5981));
        repeat (9) @(posedge clock_i);
        pins_chk(5'h1F, 2'h0, 1'b0);
        rst_i <= 1'b0;
        rd(TCS_OFS_STATUS, 32'h0);
        rd(TCS_OFS_INT_STAT, 32'h0);
        rd(TCS_OFS_INT_MASK, 32'h0);
        rd(TCS_OFS_CTRL, 32'h0);
        rd(TCS_OFS_PINS, 32'h1F);
        for (int i = 0; i < 32; i++) begin
            msk = 5'($urandom);
            ctl = 1'($urandom);
            sn  = 1'($urandom);
            rg  = ($urandom % 4) != 0;
            s   = tcs_tc_state_e'(i[2:0]);
            c2  = i[4];
            wr(TCS_OFS_INT_MASK, {27'h0, msk});
            wr(TCS_OFS_CTRL, {31'h0, ctl});
            // sense settles first so each status bit moves at most twice
            sense_i <= sn;
            range_i <= rg;
            repeat (8) @(posedge clock_i);
            tc_state_i <= s;
            src_role_i <= i[3];
            cc2_i      <= c2;
            repeat (8) @(posedge clock_i);
            att = (s != tcs_st_unattached) && (s != tcs_st_other);
            st[0] = att & sn & rg;
            st[1] = att;
            st[2] = !i[3] && (s == tcs_st_dbg_acc_snk);
            st[3] = i[3] && (s == tcs_st_unor_dbg_src || s == tcs_st_or_dbg_src);
            st[4] = att & c2;
            vc  = ctl & i[3] & (s == tcs_st_attached_src);
            mid = {prev[4:1], prev[1] & sn & rg};
            flg = (prev ^ mid) | (mid ^ st);
            pins_chk(~st, {vc & !c2, vc & c2}, |(flg & msk));
            rd(TCS_OFS_STATUS, {25'h0, vc & !c2, vc & c2, st});
            rd(TCS_OFS_PINS, {27'h0, ~st});
            rd(TCS_OFS_INT_MASK, {27'h0, msk});
            rd(TCS_OFS_INT_STAT, {27'h0, flg});
            pins_chk(~st, {vc & !c2, vc & c2}, 1'b0);
            prev = st;
        end
        wr(TCS_OFS_NONE, 32'hFFFFFFFF);
        rd(TCS_OFS_NONE, 32'h0);
        wr(TCS_OFS_STATUS, 32'h0000007F);
        rd(TCS_OFS_STATUS, {27'h0, prev});
        wr(TCS_OFS_INT_MASK, 32'h0000001F);
        tc_state_i <= tcs_st_attached_snk;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b1;
        @(posedge clock_i);
        pins_chk(5'h1F, 2'h0, 1'b0);
        rst_i <= 1'b0;
        rd(TCS_OFS_INT_MASK, 32'h0);
        rd(TCS_OFS_CTRL, 32'h0);
        tally_and_finish();
    end
endmodule : tcs_status_top_tb_top
`default_nettype wire
